// file: rtl/mstp_top.v
`timescale 1ns/100ps
`include "mstp_regs.vh"

module mstp_coil_loop #(
  parameter PERIOD = 500,
  parameter TRANS = 20,
  parameter DEAD = 3
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // control
  input wire enable,
  input wire brake_on,
  input wire [9:0] mag,
  input wire neg,
  input wire [9:0] pwm_cnt,
  // sensing, already synchronised
  input wire cur_high,
  input wire [3:0] vds_high,
  // bridge
  output reg [3:0] gate_reg,
  output reg top_reg,
  output reg fast_reg,
  output reg [3:0] fault_reg
);
  localparam HALF_I = PERIOD / 2;
  localparam THREE_Q_I = (PERIOD * 3) / 4;
  localparam [9:0] HALF = HALF_I[9:0];
  localparam [9:0] THREE_Q = THREE_Q_I[9:0];
  localparam [7:0] DEAD_C = DEAD[7:0];
  localparam [7:0] TRANS_C = TRANS[7:0];

  reg on_reg;
  reg [9:0] mag_last_reg;
  reg [7:0] dead_reg;
  reg [3:0] des;
  wire [3:0] fwd;
  wire [3:0] rev;
  genvar g;

  assign fwd = neg ? 4'hA ^ 4'hC : 4'h9;
  assign rev = neg ? 4'h9 : 4'h6;

  // on at period start, off at comparator trip
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      on_reg <= 1'b0;
      top_reg <= 1'b0;
      fast_reg <= 1'b0;
      mag_last_reg <= 10'h000;
    end
    else if (!enable)
    begin
      on_reg <= 1'b0;
      top_reg <= 1'b0;
      fast_reg <= 1'b0;
      mag_last_reg <= 10'h000;
    end
    else if (pwm_cnt == 10'h000)
    begin
      on_reg <= (mag != 10'h000);
      fast_reg <= (mag < mag_last_reg);
      mag_last_reg <= mag;
    end
    else
    begin
      // in top mode decay never starts before half period
      if (on_reg && cur_high && (!top_reg || pwm_cnt >= HALF))
        on_reg <= 1'b0;
      if (on_reg && !cur_high && pwm_cnt == THREE_Q - 10'h001)
        top_reg <= 1'b1;
      else if (on_reg && cur_high && pwm_cnt < HALF)
        top_reg <= 1'b0;
    end
  end

  always @*
  begin
    if (!enable)
      des = 4'h0;
    else if (brake_on)
      des = `MSTP_G_BRAKE;
    else if (on_reg)
      des = fwd;
    else if (fast_reg)
      des = rev;
    else
      des = `MSTP_G_BRAKE;
    des = des & ~fault_reg;
  end

  // interlock: all off for the dead time on every pattern change
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_reg <= 4'h0;
      dead_reg <= 8'h00;
    end
    else if (des != gate_reg && gate_reg != 4'h0)
    begin
      gate_reg <= 4'h0;
      dead_reg <= DEAD_C;
    end
    else if (dead_reg != 8'h00)
      dead_reg <= dead_reg - 8'h01;
    else
      gate_reg <= des;
  end

  // short protection per switch, cleared only by disabling the motor
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_sw
      reg [7:0] vcnt_reg;
      always @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          vcnt_reg <= 8'h00;
          fault_reg[g] <= 1'b0;
        end
        else if (!enable)
        begin
          vcnt_reg <= 8'h00;
          fault_reg[g] <= 1'b0;
        end
        else if (gate_reg[g] && vds_high[g])
        begin
          if (vcnt_reg >= TRANS_C)
            fault_reg[g] <= 1'b1;
          else
            vcnt_reg <= vcnt_reg + 8'h01;
        end
        else
          vcnt_reg <= 8'h00;
      end
    end
  endgenerate
endmodule

module mstp_top #(
  parameter CLK_NS = `MSTP_CLK_NS,
  parameter PWM_PERIOD_NS = `MSTP_PWM_PERIOD_NS
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // step and direction pins
  input wire step_pulse_in,
  input wire dir_pin,
  // serial pins
  input wire serial_clk,
  input wire serial_cs_n,
  input wire serial_in,
  // control bits
  input wire motor_drive_enable,
  input wire brake_request,
  input wire [2:0] step_resolution_sel,
  input wire direction_polarity,
  input wire soft_step_request,
  input wire pos_wr_en,
  input wire [5:0] pos_wr_data,
  // analog sense, asynchronous
  input wire cur_high_x,
  input wire cur_high_y,
  input wire [3:0] vds_high_x,
  input wire [3:0] vds_high_y,
  // status
  output reg [5:0] translator_position,
  output reg [2:0] res_in_force_reg,
  output wire full_step,
  output wire soft_step_pending,
  output reg dir_pin_state_reg,
  output reg [9:0] setpoint_x_reg,
  output reg setpoint_x_neg_reg,
  output reg [9:0] setpoint_y_reg,
  output reg setpoint_y_neg_reg,
  output wire top_reg_x,
  output wire top_reg_y,
  output wire fast_decay_x,
  output wire fast_decay_y,
  output wire [3:0] fault_x,
  output wire [3:0] fault_y,
  // serial receive
  output reg [7:0] serial_rx_data_reg,
  output reg serial_rx_valid_reg,
  // bridges
  output wire [3:0] gate_x,
  output wire [3:0] gate_y,
  output reg bridge_hiz_reg
);
  localparam PERIOD = (PWM_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam TRANS = (`MSTP_TRANS_NS + CLK_NS - 1) / CLK_NS;
  localparam DEAD = (`MSTP_DEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam [9:0] PERIOD_C = PERIOD[9:0];

  // two-flop synchronisers; stage 1 feeds only stage 2
  reg [7:0] s1_reg;
  reg [7:0] s2_reg;
  reg [15:0] v1_reg;
  reg [15:0] v2_reg;
  reg step_d_reg;
  reg sclk_d_reg;
  reg soft_pend_reg;
  reg [9:0] pwm_cnt_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [2:0] shift;
  reg [5:0] stride;
  reg [5:0] aligned;
  reg [5:0] pos_next;
  wire step_edge;
  wire step_now;
  wire dir_eff;
  wire sclk_rise;
  wire x_active;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= 8'h00;
      s2_reg <= 8'h00;
      v1_reg <= 16'h0000;
      v2_reg <= 16'h0000;
      step_d_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= {2'h0, cur_high_y, cur_high_x, serial_in, serial_cs_n, serial_clk, step_pulse_in};
      s2_reg <= s1_reg;
      v1_reg <= {vds_high_y, vds_high_x, 8'h00} | {8'h00, 7'h00, dir_pin};
      v2_reg <= v1_reg;
      step_d_reg <= s2_reg[0];
      sclk_d_reg <= s2_reg[1];
    end
  end

  assign step_edge = s2_reg[0] & ~step_d_reg;
  assign step_now = step_edge | soft_pend_reg;
  assign dir_eff = v2_reg[0] ^ direction_polarity;
  assign soft_step_pending = soft_pend_reg;
  assign full_step = (res_in_force_reg >= `MSTP_RES_FULL);

  // resolution to grid stride; unused codes act as full step
  always @*
  begin
    case (step_resolution_sel)
      `MSTP_RES_16: shift = 3'h0;
      `MSTP_RES_8: shift = 3'h1;
      `MSTP_RES_4: shift = 3'h2;
      `MSTP_RES_2: shift = 3'h3;
      default: shift = 3'h4;
    endcase
    stride = 6'h01 << shift;
    aligned = translator_position & ~(stride - 6'h01);
    if (aligned != translator_position)
      pos_next = dir_eff ? aligned + stride : aligned;
    else
      pos_next = dir_eff ? translator_position + stride : translator_position - stride;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      translator_position <= `MSTP_POS_RESET;
      res_in_force_reg <= `MSTP_RES_16;
      soft_pend_reg <= 1'b0;
      dir_pin_state_reg <= 1'b0;
    end
    else
    begin
      dir_pin_state_reg <= v2_reg[0];
      // a new request in the step cycle is kept for the next step
      soft_pend_reg <= soft_step_request | (soft_pend_reg & ~step_now);
      if (pos_wr_en)
        translator_position <= pos_wr_data;
      else if (step_now)
      begin
        translator_position <= pos_next;
        res_in_force_reg <= step_resolution_sel;
      end
    end
  end

  // quarter-wave table in tenths of a percent
  function [9:0] qsin;
    input [4:0] k;
    begin
      case (k)
        5'd0: qsin = 10'd0;
        5'd1: qsin = 10'd98;
        5'd2: qsin = 10'd195;
        5'd3: qsin = 10'd290;
        5'd4: qsin = 10'd383;
        5'd5: qsin = 10'd471;
        5'd6: qsin = 10'd556;
        5'd7: qsin = 10'd634;
        5'd8: qsin = 10'd707;
        5'd9: qsin = 10'd773;
        5'd10: qsin = 10'd831;
        5'd11: qsin = 10'd882;
        5'd12: qsin = 10'd924;
        5'd13: qsin = 10'd957;
        5'd14: qsin = 10'd981;
        5'd15: qsin = 10'd995;
        default: qsin = 10'd1000;
      endcase
    end
  endfunction

  wire [4:0] idx = {1'b0, translator_position[3:0]};
  wire [4:0] cidx = 5'h10 - idx;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      setpoint_x_reg <= 10'h000;
      setpoint_x_neg_reg <= 1'b0;
      setpoint_y_reg <= 10'h000;
      setpoint_y_neg_reg <= 1'b0;
    end
    else
    begin
      setpoint_x_reg <= translator_position[4] ? qsin(idx) : qsin(cidx);
      setpoint_y_reg <= translator_position[4] ? qsin(cidx) : qsin(idx);
      setpoint_x_neg_reg <= translator_position[5] ^ translator_position[4];
      setpoint_y_neg_reg <= translator_position[5];
    end
  end

  // shared pwm clock keeps both loops aligned; held at zero when disabled
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pwm_cnt_reg <= 10'h000;
    else if (!motor_drive_enable || pwm_cnt_reg == PERIOD_C - 10'h001)
      pwm_cnt_reg <= 10'h000;
    else
      pwm_cnt_reg <= pwm_cnt_reg + 10'h001;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      bridge_hiz_reg <= 1'b1;
    else
      bridge_hiz_reg <= ~motor_drive_enable;
  end

  assign x_active = (setpoint_x_reg >= setpoint_y_reg);

  mstp_coil_loop #(.PERIOD(PERIOD), .TRANS(TRANS), .DEAD(DEAD)) u_loop_x (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .enable(motor_drive_enable),
    .brake_on(brake_request & x_active),
    .mag(setpoint_x_reg),
    .neg(setpoint_x_neg_reg),
    .pwm_cnt(pwm_cnt_reg),
    .cur_high(s2_reg[4]),
    .vds_high(v2_reg[11:8]),
    .gate_reg(gate_x),
    .top_reg(top_reg_x),
    .fast_reg(fast_decay_x),
    .fault_reg(fault_x)
  );

  mstp_coil_loop #(.PERIOD(PERIOD), .TRANS(TRANS), .DEAD(DEAD)) u_loop_y (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .enable(motor_drive_enable),
    .brake_on(brake_request & ~x_active),
    .mag(setpoint_y_reg),
    .neg(setpoint_y_neg_reg),
    .pwm_cnt(pwm_cnt_reg),
    .cur_high(s2_reg[5]),
    .vds_high(v2_reg[15:12]),
    .gate_reg(gate_y),
    .top_reg(top_reg_y),
    .fast_reg(fast_decay_y),
    .fault_reg(fault_y)
  );

  // serial receive; clock must stay well below clk_sys/4
  assign sclk_rise = s2_reg[1] & ~sclk_d_reg & ~s2_reg[2];

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      serial_rx_data_reg <= 8'h00;
      serial_rx_valid_reg <= 1'b0;
    end
    else
    begin
      serial_rx_valid_reg <= 1'b0;
      if (s2_reg[2])
        bit_cnt_reg <= 3'h0;
      else if (sclk_rise)
      begin
        shift_reg <= {shift_reg[6:0], s2_reg[3]};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7)
        begin
          serial_rx_data_reg <= {shift_reg[6:0], s2_reg[3]};
          serial_rx_valid_reg <= 1'b1;
        end
      end
    end
  end
endmodule

// file: inc/mstp_regs.vh
// How it works
// - two independent current loops, one per bridge and coil
// - comparator result switches bridge, edges aligned to pwm clock counter
// - pwm period fixed, from internal clock, no tuning input
// - dead time with all switches off between any two drive patterns
// - switch with high voltage longer than transition time is latched off
// - enable low: bridges off and pwm stopped, translator keeps working
// - enable high restarts regulation at present position currents
// - forward plus slow decay; fast decay when set-point dropped
// - set-point missed by 75% of period: top regulation, duty above half
// - top regulation flag kept per winding x and y
// - brake: both low sides of the position's active bridge on
// - resolution codes 000 sixteenth up to 100 full step
// - reset gives sixteenth step at position 8, steps of one
// - coarser resolution clears low bits, rounds by direction
// - finer resolution keeps position, new low bits zero
// - resolution change applies only at the next step trigger
// - each trigger moves to next grid position in chosen direction
// - full step uses 0, 16, 32, 48 with one coil only
// - position maps to cosine x and sine y set-points
// - coarse modes use every 2nd, 4th, 8th, 16th table entry
// - serial bits sampled at rising serial clock while select low
// - direction is pin xor polarity bit
// - step on rising step pin or soft request, request self-clears
// - position write applies at once whatever the resolution
`ifndef MSTP_REGS_VH
`define MSTP_REGS_VH
`define MSTP_POS_RESET 6'h08
`define MSTP_RES_16 3'h0
`define MSTP_RES_8 3'h1
`define MSTP_RES_4 3'h2
`define MSTP_RES_2 3'h3
`define MSTP_RES_FULL 3'h4
`define MSTP_CLK_NS 100
`define MSTP_PWM_PERIOD_NS 50000
`define MSTP_TRANS_NS 2000
`define MSTP_DEAD_NS 300
`define MSTP_G_HSA 3
`define MSTP_G_LSA 2
`define MSTP_G_HSB 1
`define MSTP_G_LSB 0
`define MSTP_G_BRAKE 4'h5
`endif

// file: bench/mstp_mcu_model.sv
`timescale 1ns/100ps
module mstp_mcu_model (
  // clock
  input wire clk_sys,
  // pins toward the driver
  output logic step_pulse_in,
  output logic dir_pin,
  output logic serial_clk,
  output logic serial_cs_n,
  output logic serial_in
);
  initial
  begin
    step_pulse_in = 1'b0;
    dir_pin = 1'b0;
    serial_clk = 1'b0;
    serial_cs_n = 1'b1;
    serial_in = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // direction settles 25 us before the pulse and holds 27 us after it
  task automatic step(input logic d);
    dir_pin <= d;
    wait_clk(250);
    step_pulse_in <= 1'b1;
    wait_clk(20);
    step_pulse_in <= 1'b0;
    wait_clk(270);
  endtask
  // 800 ns serial clock, still outside frames, msb first
  task automatic send(input logic [7:0] b);
    serial_cs_n <= 1'b0;
    wait_clk(5);
    for (int i = 7; i >= 0; i--)
    begin
      serial_in <= b[i];
      wait_clk(4);
      serial_clk <= 1'b1;
      wait_clk(4);
      serial_clk <= 1'b0;
    end
    wait_clk(5);
    serial_cs_n <= 1'b1;
    // a released line must not keep showing the last bit
    serial_in <= ~b[0];
    wait_clk(10);
  endtask
endmodule

// file: bench/mstp_top_props.sv
`timescale 1ns/100ps
`include "mstp_regs.vh"
module mstp_props (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // watched inputs
  input wire motor_drive_enable,
  input wire brake_request,
  input wire soft_step_request,
  input wire pos_wr_en,
  input wire [3:0] vds_high_x,
  // watched outputs
  input wire [5:0] translator_position,
  input wire full_step,
  input wire soft_step_pending,
  input wire [9:0] setpoint_x_reg,
  input wire setpoint_x_neg_reg,
  input wire [9:0] setpoint_y_reg,
  input wire setpoint_y_neg_reg,
  input wire [3:0] gate_x,
  input wire [3:0] gate_y,
  input wire [3:0] fault_x,
  input wire bridge_hiz_reg
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic [7:0] short_cnt;
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      short_cnt <= 8'h00;
    else if (|(gate_x & vds_high_x))
      short_cnt <= short_cnt + 8'h01;
    else
      short_cnt <= 8'h00;
  end
  hiz_off_a: assert property ((!motor_drive_enable) [*3] |-> gate_x == 4'h0 && gate_y == 4'h0 && bridge_hiz_reg)
    else $error("bridge driven while disabled");
  no_shoot_a: assert property (gate_x[3:2] != 2'h3 && gate_x[1:0] != 2'h3 && gate_y[3:2] != 2'h3 && gate_y[1:0] != 2'h3)
    else $error("half bridge shoot through");
  dead_gap_a: assert property ($changed(gate_x) && (gate_x & ~$past(gate_x)) != 4'h0 |->
    $past(gate_x) == 4'h0 && $past(gate_x, 3) == 4'h0) else $error("switch on without dead time");
  soft_move_a: assert property (soft_step_request && !pos_wr_en ##1 !pos_wr_en |=> $changed(translator_position))
    else $error("soft step not taken");
  pend_clear_a: assert property (soft_step_pending && !soft_step_request |=> !soft_step_pending)
    else $error("soft step request stuck");
  full_grid_a: assert property (full_step && $changed(translator_position) && !$past(pos_wr_en) &&
    !$past(pos_wr_en, 2) |-> translator_position[3:0] == 4'h0) else $error("full step off grid");
  x_axis_a: assert property (translator_position[4:0] == 5'h00 |=> setpoint_x_reg == 10'h3E8 &&
    setpoint_y_reg == 10'h000 && setpoint_x_neg_reg == $past(translator_position[5])) else $error("x axis setpoint");
  y_axis_a: assert property (translator_position[4:0] == 5'h10 |=> setpoint_y_reg == 10'h3E8 &&
    setpoint_x_reg == 10'h000 && setpoint_y_neg_reg == $past(translator_position[5])) else $error("y axis setpoint");
  brake_low_a: assert property ((motor_drive_enable && brake_request) [*8] |->
    gate_x == `MSTP_G_BRAKE || gate_y == `MSTP_G_BRAKE) else $error("brake pattern missing");
  short_off_a: assert property (short_cnt < 8'h20)
    else $error("shorted switch left on");
  cover property (soft_step_request);
  cover property (motor_drive_enable && brake_request);
  cover property (fault_x != 4'h0);
endmodule
bind mstp_top mstp_props u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .motor_drive_enable(motor_drive_enable), .brake_request(brake_request),
  .soft_step_request(soft_step_request), .pos_wr_en(pos_wr_en), .vds_high_x(vds_high_x),
  .translator_position(translator_position), .full_step(full_step), .soft_step_pending(soft_step_pending),
  .setpoint_x_reg(setpoint_x_reg), .setpoint_x_neg_reg(setpoint_x_neg_reg), .setpoint_y_reg(setpoint_y_reg),
  .setpoint_y_neg_reg(setpoint_y_neg_reg), .gate_x(gate_x), .gate_y(gate_y), .fault_x(fault_x),
  .bridge_hiz_reg(bridge_hiz_reg)
);

// file: bench/mstp_top_tb.sv
`timescale 1ns/100ps
module mstp_top_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic motor_drive_enable = 1'b0, brake_request = 1'b0, direction_polarity = 1'b0, soft_step_request = 1'b0;
  logic pos_wr_en = 1'b0, cur_high_x = 1'b0, cur_high_y = 1'b1;
  logic [2:0] step_resolution_sel = 3'h0;
  logic [5:0] pos_wr_data = 6'h00, pos_e = 6'h08, pos_prev;
  logic [3:0] vds_high_x = 4'h0, vds_high_y = 4'h0;
  wire step_pulse_in, dir_pin, serial_clk, serial_cs_n, serial_in, full_step, soft_step_pending;
  wire setpoint_x_neg_reg, setpoint_y_neg_reg, serial_rx_valid_reg, bridge_hiz_reg, top_reg_x, fast_decay_x;
  wire [5:0] translator_position;
  wire [9:0] setpoint_x_reg, setpoint_y_reg;
  wire [3:0] gate_x, gate_y, fault_x, fault_y;
  wire [2:0] res_in_force_reg;
  wire dir_pin_state_reg, top_reg_y, fast_decay_y;
  wire [7:0] serial_rx_data_reg;
  int n_errors = 0, n_checks = 0, cyc = 0;
  logic [5:0] pos_q[$];
  logic [7:0] rx_q[$];
  logic [5:0] wp[5] = '{6'h05, 6'h30, 6'h20, 6'h10, 6'h00};
  logic [10:0] ex[5] = '{11'h372, 11'h000, 11'h7E8, 11'h000, 11'h3E8};
  logic [10:0] ey[5] = '{11'h1D7, 11'h7E8, 11'h000, 11'h3E8, 11'h000};
  always #50 clk_sys = ~clk_sys;
  mstp_mcu_model u_mcu (.clk_sys(clk_sys), .step_pulse_in(step_pulse_in), .dir_pin(dir_pin),
    .serial_clk(serial_clk), .serial_cs_n(serial_cs_n), .serial_in(serial_in));
  // 5 us period keeps each regulation cycle at 50 clocks
  mstp_top #(.PWM_PERIOD_NS(5000)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .step_pulse_in(step_pulse_in),
    .dir_pin(dir_pin), .serial_clk(serial_clk), .serial_cs_n(serial_cs_n), .serial_in(serial_in),
    .motor_drive_enable(motor_drive_enable), .brake_request(brake_request), .step_resolution_sel(step_resolution_sel),
    .direction_polarity(direction_polarity), .soft_step_request(soft_step_request), .pos_wr_en(pos_wr_en),
    .pos_wr_data(pos_wr_data), .cur_high_x(cur_high_x), .cur_high_y(cur_high_y), .vds_high_x(vds_high_x),
    .vds_high_y(vds_high_y), .translator_position(translator_position), .res_in_force_reg(res_in_force_reg),
    .full_step(full_step), .soft_step_pending(soft_step_pending), .dir_pin_state_reg(dir_pin_state_reg),
    .setpoint_x_reg(setpoint_x_reg),
    .setpoint_x_neg_reg(setpoint_x_neg_reg), .setpoint_y_reg(setpoint_y_reg), .setpoint_y_neg_reg(setpoint_y_neg_reg),
    .top_reg_x(top_reg_x), .top_reg_y(top_reg_y), .fast_decay_x(fast_decay_x), .fast_decay_y(fast_decay_y),
    .fault_x(fault_x), .fault_y(fault_y), .serial_rx_data_reg(serial_rx_data_reg),
    .serial_rx_valid_reg(serial_rx_valid_reg),
    .gate_x(gate_x), .gate_y(gate_y), .bridge_hiz_reg(bridge_hiz_reg));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [5:0] next_pos(input logic [5:0] p, input logic [2:0] s, input logic up);
    logic [5:0] st;
    logic [5:0] g;
    st = (s > 3'h3) ? 6'h10 : 6'h01 << s;
    g = p & ~(st - 6'h01);
    if (g != p)
      return up ? g + st : g;
    return up ? p + st : p - st;
  endfunction
  function automatic logic [3:0] probe(input int w);
    case (w)
      0: return gate_x;
      1: return {3'h0, top_reg_x};
      2: return {3'h0, fast_decay_x};
      default: return fault_x;
    endcase
  endfunction
  task automatic wait_for(input string nm, input int w, input logic [3:0] v);
    for (int k = 0; k < 300 && probe(w) !== v; k++)
      @(posedge clk_sys);
    check(nm, probe(w), v);
  endtask
  task automatic do_step(input logic [2:0] s, input logic pol, input logic d, input logic pin);
    @(posedge clk_sys);
    step_resolution_sel <= s;
    direction_polarity <= pol;
    if (!pin)
      d = dir_pin;
    pos_e = next_pos(pos_e, s, d ^ pol);
    pos_q.push_back(pos_e);
    if (pin)
      u_mcu.step(d);
    else
    begin
      soft_step_request <= 1'b1;
      @(posedge clk_sys);
      soft_step_request <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    check("res in force", {full_step, res_in_force_reg}, {s > 3'h3, s});
    check("dir state", dir_pin_state_reg, dir_pin);
  endtask
  task automatic wr_pos(input logic [5:0] p);
    @(posedge clk_sys);
    pos_wr_en <= 1'b1;
    pos_wr_data <= p;
    if (p != pos_e)
      pos_q.push_back(p);
    pos_e = p;
    @(posedge clk_sys);
    pos_wr_en <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  always @(posedge clk_sys)
  begin
    pos_prev <= translator_position;
    if (rst_n && translator_position !== pos_prev)
    begin
      if (pos_q.size() == 0)
        check("stray move", 1'b1, 1'b0);
      else
        check("position", translator_position, pos_q.pop_front());
    end
    if (serial_rx_valid_reg === 1'b1)
      check("rx byte", serial_rx_data_reg, rx_q.pop_front());
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_errors++;
      end_sim();
    end
  end
  initial
  begin
    void'($urandom(78));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    check("reset pos", {setpoint_x_reg, translator_position}, {10'h2C3, 6'h08});
    check("reset y", {bridge_hiz_reg, setpoint_y_reg}, {1'b1, 10'h2C3});
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 40; i++)
      do_step(i < 8 ? i[2:0] : 3'($urandom), 1'($urandom), 1'($urandom), i % 4 == 3);
    for (int i = 0; i < 5; i++)
    begin
      wr_pos(wp[i]);
      check("sp x", {setpoint_x_neg_reg & (ex[i][9:0] != 10'h000), setpoint_x_reg}, ex[i]);
      check("sp y", {setpoint_y_neg_reg & (ey[i][9:0] != 10'h000), setpoint_y_reg}, ey[i]);
    end
    motor_drive_enable <= 1'b1;
    wait_for("forward", 0, 4'h9);
    // a zero set-point coil sits in slow decay, not off
    check("coil y idle", gate_y, 4'h5);
    check("y flags", {top_reg_y, fast_decay_y, fault_y}, 6'h00);
    wait_for("top flag", 1, 4'h1);
    cur_high_x <= 1'b1;
    wait_for("slow decay", 0, 4'h5);
    cur_high_x <= 1'b0;
    brake_request <= 1'b1;
    repeat (60) @(posedge clk_sys);
    wait_for("brake", 0, 4'h5);
    brake_request <= 1'b0;
    cur_high_x <= 1'b1;
    wr_pos(6'h08);
    wait_for("fast decay", 2, 4'h1);
    cur_high_x <= 1'b0;
    wait_for("forward", 0, 4'h9);
    vds_high_x <= 4'h8;
    wait_for("short", 3, 4'h8);
    check("fault y", fault_y, 4'h0);
    vds_high_x <= 4'h0;
    motor_drive_enable <= 1'b0;
    wait_for("off", 0, 4'h0);
    do_step(3'h1, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      rx_q.push_back(8'($urandom));
      // select lowered long after wake-up
      u_mcu.send(rx_q[rx_q.size() - 1]);
    end
    repeat (10) @(posedge clk_sys);
    check("left over", pos_q.size() + rx_q.size(), 16'h0000);
    end_sim();
  end
endmodule
